// >>> hw/sfsc_regs.svh
// Register offsets, bit positions and reset values of the handler state and fault status block.
// Assumes inclusion by name from the package and modules that need the constants.
`ifndef SFSC_REGS_SVH
`define SFSC_REGS_SVH

`define SFSC_OFF_HSC 12'h000
`define SFSC_OFF_FCS 12'h004
`define SFSC_OFF_FADDR 12'h008
`define SFSC_OFF_IRQ_STAT 12'h00C
`define SFSC_OFF_IRQ_EN 12'h010
`define SFSC_OFF_IRQ_CLR 12'h014
`define SFSC_OFF_HARD 12'h018

`define SFSC_HSC_RESET 32'h0000_0000
`define SFSC_FCS_RESET 32'h0000_0000
`define SFSC_ZERO32 32'h0000_0000

// Handler control/state bit positions
`define SFSC_B_USG_EN 18
`define SFSC_B_BUS_EN 17
`define SFSC_B_MEM_EN 16
`define SFSC_B_SVC_PEND 15
`define SFSC_B_BUS_PEND 14
`define SFSC_B_MEM_PEND 13
`define SFSC_B_USG_PEND 12
`define SFSC_B_TICK_ACT 11
`define SFSC_B_DEFER_ACT 10
`define SFSC_B_DBG_ACT 8
`define SFSC_B_SVC_ACT 7
`define SFSC_B_USG_ACT 3
`define SFSC_B_BUS_ACT 1
`define SFSC_B_MEM_ACT 0
`define SFSC_HSC_MASK 32'h0007_FD8B

// Fault cause bit positions
`define SFSC_B_FETCH_VIOL 0
`define SFSC_B_DATA_VIOL 1
`define SFSC_B_MEM_RESTORE 3
`define SFSC_B_MEM_SAVE 4
`define SFSC_B_LAZY_FP 5
`define SFSC_B_MADDR_VALID 7
`define SFSC_B_BADDR_VALID 15
`define SFSC_FCS_MASK 32'h030F_9FBB
`define SFSC_MEM_CAUSE_MASK 32'h0000_00BB
`define SFSC_BUS_CAUSE_MASK 32'h0000_9F00
`define SFSC_USG_CAUSE_MASK 32'h030F_0000

// Interrupt status bits
`define SFSC_IRQ_W 4
`define SFSC_I_MEM 0
`define SFSC_I_BUS 1
`define SFSC_I_USG 2
`define SFSC_I_HARD 3

`endif

// >>> hw/sfsc_pkg.sv
// Types shared by the handler state and fault status block.
// Assumes the constants header sits next to it.
package sfsc_pkg;
    `include "sfsc_regs.svh"

    typedef enum logic [1:0] {
        SFSC_KIND_MEM = 2'b00,
        SFSC_KIND_BUS = 2'b01,
        SFSC_KIND_USG = 2'b10
    } sfsc_kind_type;

    typedef enum logic [0:0] {
        SFSC_IDLE = 1'b0,
        SFSC_ACCESS = 1'b1
    } sfsc_bus_state_type;
endpackage : sfsc_pkg

// >>> hw/sfsc_sticky.sv
// One sticky bit vector: hardware set, write-one-to-clear, set wins.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ns
module sfsc_sticky
    import sfsc_pkg::*;
#(
    parameter int W = 32
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic [W-1:0] set_bits,
    input wire logic [W-1:0] clr_bits,
    // State
    output logic [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } sfsc_sticky_state_type;

    sfsc_sticky_state_type st_reg;
    sfsc_sticky_state_type st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.flags = (st_reg.flags & ~clr_bits) | set_bits;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign flags = st_reg.flags;

    sticky_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (flags & ~clr_bits) != '0 |=> ((flags & $past(flags & ~clr_bits))
            == $past(flags & ~clr_bits)))
        else $error("sticky flag lost without clear");
    sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        set_bits != '0 |=> (flags & $past(set_bits)) == $past(set_bits))
        else $error("sticky flag not set");
endmodule : sfsc_sticky

// >>> hw/sfsc_fault_latch.sv
// Fault cause recorder: turns fault events into cause flags and the fault address.
// Assumes fault events are one-cycle pulses from core logic on pclk.
`timescale 1ns/1ns
module sfsc_fault_latch
    import sfsc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fault events
    input wire logic fetch_fault,
    input wire logic data_fault,
    input wire logic [31:0] data_fault_addr,
    input wire logic restore_fault,
    input wire logic save_fault,
    input wire logic lazy_fp_active,
    input wire logic [31:0] bus_cause_set,
    input wire logic [31:0] usage_cause_set,
    // Software side
    input wire logic [31:0] sw_clear,
    input wire logic addr_wr,
    input wire logic [31:0] addr_wdata,
    // State
    output logic [31:0] cause,
    output logic [31:0] fault_addr
);
    typedef struct packed {
        logic [31:0] addr;
    } sfsc_latch_state_type;

    sfsc_latch_state_type st_reg;
    sfsc_latch_state_type st_next;
    logic [31:0] set_bits;
    logic mem_event;

    always_comb
    begin
        mem_event = fetch_fault | data_fault | restore_fault | save_fault;
        set_bits = (bus_cause_set & `SFSC_BUS_CAUSE_MASK)
                 | (usage_cause_set & `SFSC_USG_CAUSE_MASK);
        set_bits[`SFSC_B_FETCH_VIOL] = fetch_fault;
        set_bits[`SFSC_B_DATA_VIOL] = data_fault;
        set_bits[`SFSC_B_MADDR_VALID] = data_fault;
        set_bits[`SFSC_B_MEM_RESTORE] = restore_fault;
        set_bits[`SFSC_B_MEM_SAVE] = save_fault;
        set_bits[`SFSC_B_LAZY_FP] = mem_event & lazy_fp_active;
        st_next = st_reg;
        if (addr_wr)
            st_next.addr = addr_wdata;
        // Only data violations carry a known address
        if (data_fault)
            st_next.addr = data_fault_addr;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    sfsc_sticky #(.W(32)) u_cause (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(set_bits),
        .clr_bits(sw_clear & `SFSC_FCS_MASK),
        .flags(cause)
    );

    assign fault_addr = st_reg.addr;

    addr_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        data_fault |=> fault_addr == $past(data_fault_addr) && cause[`SFSC_B_DATA_VIOL])
        else $error("data fault address not captured");
    addr_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (fetch_fault || restore_fault || save_fault) && !data_fault && !addr_wr
        |=> $stable(fault_addr))
        else $error("fault address written by non-data fault");
    lazy_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cause[`SFSC_B_LAZY_FP] && !lazy_fp_active |=> !cause[`SFSC_B_LAZY_FP])
        else $error("lazy flag set without lazy save");
endmodule : sfsc_fault_latch

// >>> hw/sfsc_top.sv
// Handler state/control and fault cause status block, an APB slave.
// Assumes fault and handler events are pclk-synchronous pulses from core logic.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module sfsc_top
    import sfsc_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fault requests from core
    input wire logic fault_req,
    input wire logic [1:0] fault_kind,
    input wire logic fetch_fault,
    input wire logic data_fault,
    input wire logic [31:0] data_fault_addr,
    input wire logic restore_fault,
    input wire logic save_fault,
    input wire logic lazy_fp_active,
    input wire logic [31:0] bus_cause_set,
    input wire logic [31:0] usage_cause_set,
    // Handler events from core
    input wire logic [31:0] hsc_set,
    input wire logic [31:0] hsc_clr,
    // Handler outputs
    output logic [2:0] fault_take,
    output logic hard_fault,
    output logic irq
);
    typedef struct packed {
        logic [31:0] hsc;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic [`SFSC_IRQ_W-1:0] irq_en;
        logic irq;
        logic [2:0] take;
        logic hard;
        logic [31:0] hard_count;
    } sfsc_state_type;

    sfsc_state_type st_reg;
    sfsc_state_type st_next;

    logic [31:0] cause;
    logic [31:0] fault_addr;
    logic [`SFSC_IRQ_W-1:0] irq_stat;
    logic [`SFSC_IRQ_W-1:0] irq_set;
    logic [`SFSC_IRQ_W-1:0] irq_clr;
    logic [31:0] fcs_clear;
    logic addr_wr;
    logic setup;
    logic wr_en;
    logic handler_on;
    logic escalate;
    logic mapped;

    always_comb
    begin
        setup = psel && !penable;
        wr_en = psel && penable && pwrite && st_reg.ready;
        mapped = (paddr == `SFSC_OFF_HSC) || (paddr == `SFSC_OFF_FCS)
              || (paddr == `SFSC_OFF_FADDR) || (paddr == `SFSC_OFF_IRQ_STAT)
              || (paddr == `SFSC_OFF_IRQ_EN) || (paddr == `SFSC_OFF_IRQ_CLR)
              || (paddr == `SFSC_OFF_HARD);
        case (fault_kind)
            SFSC_KIND_MEM: handler_on = st_reg.hsc[`SFSC_B_MEM_EN];
            SFSC_KIND_BUS: handler_on = st_reg.hsc[`SFSC_B_BUS_EN];
            SFSC_KIND_USG: handler_on = st_reg.hsc[`SFSC_B_USG_EN];
            default: handler_on = 1'b0;
        endcase
        escalate = fault_req && !handler_on;
        fcs_clear = (wr_en && paddr == `SFSC_OFF_FCS) ? pwdata : `SFSC_ZERO32;
        addr_wr = wr_en && paddr == `SFSC_OFF_FADDR;
        irq_clr = (wr_en && paddr == `SFSC_OFF_IRQ_CLR) ? pwdata[`SFSC_IRQ_W-1:0] : '0;
        irq_set = '0;
        irq_set[`SFSC_I_MEM] = fault_req && !escalate && fault_kind == SFSC_KIND_MEM;
        irq_set[`SFSC_I_BUS] = fault_req && !escalate && fault_kind == SFSC_KIND_BUS;
        irq_set[`SFSC_I_USG] = fault_req && !escalate && fault_kind == SFSC_KIND_USG;
        irq_set[`SFSC_I_HARD] = escalate;

        st_next = st_reg;
        // No wait states: ready answers every setup cycle, so a write lands one edge later
        st_next.ready = setup;
        st_next.slverr = setup && !mapped;
        st_next.take = '0;
        st_next.hard = escalate;
        if (fault_req && !escalate)
            st_next.take[fault_kind] = 1'b1;
        // Escalation count wraps rather than saturates; software only watches it move
        if (escalate)
            st_next.hard_count = st_reg.hard_count + 32'h0000_0001;

        // Core updates, then a software write replaces the whole register
        st_next.hsc = ((st_reg.hsc & ~hsc_clr) | hsc_set) & `SFSC_HSC_MASK;
        if (fault_req && !escalate)
        begin
            case (fault_kind)
                SFSC_KIND_MEM: st_next.hsc[`SFSC_B_MEM_PEND] = 1'b1;
                SFSC_KIND_BUS: st_next.hsc[`SFSC_B_BUS_PEND] = 1'b1;
                SFSC_KIND_USG: st_next.hsc[`SFSC_B_USG_PEND] = 1'b1;
                default: st_next.hsc = st_next.hsc;
            endcase
        end
        if (wr_en && paddr == `SFSC_OFF_HSC)
            st_next.hsc = pwdata & `SFSC_HSC_MASK;
        if (wr_en && paddr == `SFSC_OFF_IRQ_EN)
            st_next.irq_en = pwdata[`SFSC_IRQ_W-1:0];
        st_next.irq = |(((irq_stat & ~irq_clr) | irq_set) & st_next.irq_en);

        st_next.rdata = `SFSC_ZERO32;
        if (setup && !pwrite)
        begin
            case (paddr)
                `SFSC_OFF_HSC: st_next.rdata = st_reg.hsc;
                `SFSC_OFF_FCS: st_next.rdata = cause & `SFSC_FCS_MASK;
                `SFSC_OFF_FADDR: st_next.rdata = fault_addr;
                `SFSC_OFF_IRQ_STAT: st_next.rdata[`SFSC_IRQ_W-1:0] = irq_stat;
                `SFSC_OFF_IRQ_EN: st_next.rdata[`SFSC_IRQ_W-1:0] = st_reg.irq_en;
                `SFSC_OFF_HARD: st_next.rdata = st_reg.hard_count;
                default: st_next.rdata = `SFSC_ZERO32;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= '0;
            st_reg.hsc <= `SFSC_HSC_RESET;
        end
        else
            st_reg <= st_next;
    end

    sfsc_fault_latch u_latch (
        .pclk(pclk),
        .presetn(presetn),
        .fetch_fault(fetch_fault),
        .data_fault(data_fault),
        .data_fault_addr(data_fault_addr),
        .restore_fault(restore_fault),
        .save_fault(save_fault),
        .lazy_fp_active(lazy_fp_active),
        .bus_cause_set(bus_cause_set),
        .usage_cause_set(usage_cause_set),
        .sw_clear(fcs_clear),
        .addr_wr(addr_wr),
        .addr_wdata(pwdata),
        .cause(cause),
        .fault_addr(fault_addr)
    );

    sfsc_sticky #(.W(`SFSC_IRQ_W)) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(irq_set),
        .clr_bits(irq_clr),
        .flags(irq_stat)
    );

    assign prdata = st_reg.rdata;
    assign pready = st_reg.ready;
    assign pslverr = st_reg.slverr;
    assign fault_take = st_reg.take;
    assign hard_fault = st_reg.hard;
    assign irq = st_reg.irq;

    escalate_hard_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_req && fault_kind == SFSC_KIND_MEM && !st_reg.hsc[`SFSC_B_MEM_EN]
        |=> hard_fault && fault_take == 3'b000)
        else $error("disabled fault not escalated");
    enabled_take_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_req && fault_kind == SFSC_KIND_BUS && st_reg.hsc[`SFSC_B_BUS_EN]
        |=> !hard_fault && fault_take[1])
        else $error("enabled fault not taken");
    hsc_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `SFSC_OFF_HSC |=> st_reg.hsc == ($past(pwdata) & `SFSC_HSC_MASK))
        else $error("handler state write lost");
    hsc_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == `SFSC_OFF_HSC |=> prdata == $past(st_reg.hsc) && pready)
        else $error("handler state read wrong");
    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.hsc & ~`SFSC_HSC_MASK) == '0 && (cause & ~`SFSC_FCS_MASK) == '0)
        else $error("reserved bit set");
    pend_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_req && !escalate && fault_kind == SFSC_KIND_USG && !wr_en
        |=> st_reg.hsc[`SFSC_B_USG_PEND])
        else $error("usage pending not set");
    ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("ready timing wrong");
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(irq_stat & st_reg.irq_en))
        else $error("interrupt level wrong");

    // Bus answer checks
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !mapped |=> pslverr && pready && prdata == `SFSC_ZERO32)
        else $error("unmapped access not refused");
    err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error response without ready");
    rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == `SFSC_ZERO32)
        else $error("read data outside access cycle");
    fcs_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == `SFSC_OFF_FCS
        |=> prdata == $past(cause & `SFSC_FCS_MASK))
        else $error("fault cause read wrong");
    faddr_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == `SFSC_OFF_FADDR |=> prdata == $past(fault_addr))
        else $error("fault address read wrong");
    count_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == `SFSC_OFF_HARD |=> prdata == $past(st_reg.hard_count))
        else $error("escalation count read wrong");

    // Register update checks
    irqen_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `SFSC_OFF_IRQ_EN
        |=> st_reg.irq_en == $past(pwdata[`SFSC_IRQ_W-1:0]))
        else $error("interrupt enable write lost");
    faddr_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        addr_wr && !data_fault |=> fault_addr == $past(pwdata))
        else $error("fault address write lost");
    irq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq_clr != '0 && irq_set == '0 |=> (irq_stat & $past(irq_clr)) == '0)
        else $error("interrupt status not cleared");
    core_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        hsc_set != '0 && !wr_en
        |=> (st_reg.hsc & $past(hsc_set & `SFSC_HSC_MASK)) == $past(hsc_set & `SFSC_HSC_MASK))
        else $error("core handler state set lost");
    core_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        hsc_clr != '0 && hsc_set == '0 && !fault_req && !wr_en
        |=> (st_reg.hsc & $past(hsc_clr)) == '0)
        else $error("core handler state clear lost");

    // Fault routing, counting and reset checks
    any_escalate_a: assert property (@(posedge pclk) disable iff (!presetn)
        escalate |=> hard_fault && fault_take == 3'b000)
        else $error("escalated fault also taken");
    usg_escalate_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_req && fault_kind == SFSC_KIND_USG && !st_reg.hsc[`SFSC_B_USG_EN]
        |=> hard_fault)
        else $error("disabled usage fault not escalated");
    mem_take_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_req && fault_kind == SFSC_KIND_MEM && st_reg.hsc[`SFSC_B_MEM_EN]
        |=> fault_take == 3'b001 && !hard_fault)
        else $error("enabled memory fault not taken");
    take_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(fault_take) && !(hard_fault && fault_take != 3'b000))
        else $error("fault routed twice");
    hard_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        escalate |=> st_reg.hard_count == $past(st_reg.hard_count) + 32'h0000_0001)
        else $error("escalation not counted");
    count_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        !escalate |=> $stable(st_reg.hard_count))
        else $error("escalation count moved");
    escalate_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        escalate |=> irq_stat[`SFSC_I_HARD])
        else $error("escalation status not set");
    mem_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_req && !escalate && fault_kind == SFSC_KIND_MEM && !wr_en
        |=> st_reg.hsc[`SFSC_B_MEM_PEND])
        else $error("memory pending not set");
    bus_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_req && !escalate && fault_kind == SFSC_KIND_BUS && !wr_en
        |=> st_reg.hsc[`SFSC_B_BUS_PEND])
        else $error("bus pending not set");
    hold_reset_a: assert property (@(posedge pclk)
        $rose(presetn) |-> st_reg.hsc == `SFSC_HSC_RESET)
        else $error("handler state not reset");

    cov_escalate_c: cover property (@(posedge pclk) disable iff (!presetn) hard_fault);
    cov_write_c: cover property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `SFSC_OFF_HSC);
    cov_fcs_clear_c: cover property (@(posedge pclk) disable iff (!presetn) fcs_clear != '0);
    cov_irq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    cov_refuse_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule : sfsc_top

// >>> test/tb_top.sv
// Self-checking bench for the handler state and fault cause block.
// Assumes the bench drives APB and the core event pins itself; assertions live in the design.
`timescale 1ns/1ns
`include "sfsc_regs.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module tb_top;
    import sfsc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fault_req = 1'b0;
    logic [1:0] fault_kind = 2'b00;
    logic fetch_fault = 1'b0;
    logic data_fault = 1'b0;
    logic [31:0] data_fault_addr = 32'h0000_0000;
    logic restore_fault = 1'b0;
    logic save_fault = 1'b0;
    logic lazy_fp_active = 1'b0;
    logic [31:0] bus_cause_set = 32'h0000_0000;
    logic [31:0] usage_cause_set = 32'h0000_0000;
    logic [31:0] hsc_set = 32'h0000_0000;
    logic [31:0] hsc_clr = 32'h0000_0000;
    logic [2:0] fault_take;
    logic hard_fault;
    logic irq;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;

    sfsc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault_req(fault_req), .fault_kind(fault_kind),
        .fetch_fault(fetch_fault), .data_fault(data_fault), .data_fault_addr(data_fault_addr),
        .restore_fault(restore_fault), .save_fault(save_fault), .lazy_fp_active(lazy_fp_active),
        .bus_cause_set(bus_cause_set), .usage_cause_set(usage_cause_set), .hsc_set(hsc_set),
        .hsc_clr(hsc_clr), .fault_take(fault_take), .hard_fault(hard_fault), .irq(irq));

    initial
    begin
        forever #50 pclk = ~pclk;
    end

    // Generous ceiling; the whole sequence needs well under a thousand cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // Request is held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rdat, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd, er);
        `CHK(rd, exp)
    endtask : rd_chk

    // Lets the sampling edge pass, then drops every core pulse
    task automatic fire();
        @(posedge pclk);
        fault_req <= 1'b0;
        fetch_fault <= 1'b0;
        data_fault <= 1'b0;
        restore_fault <= 1'b0;
        save_fault <= 1'b0;
        bus_cause_set <= 32'h0000_0000;
        usage_cause_set <= 32'h0000_0000;
        hsc_set <= 32'h0000_0000;
        hsc_clr <= 32'h0000_0000;
        lazy_fp_active <= 1'b0;
        #1;
    endtask : fire

    task automatic t_reset_and_fields();
        rd_chk(`SFSC_OFF_HSC, `SFSC_HSC_RESET);
        rd_chk(`SFSC_OFF_FCS, `SFSC_FCS_RESET);
        apb(1'b1, `SFSC_OFF_HSC, 32'hFFFF_FFFF, rd, er);
        rd_chk(`SFSC_OFF_HSC, `SFSC_HSC_MASK);
        // Context switch by software: active status bits are written, then cleared to zero
        apb(1'b1, `SFSC_OFF_HSC, 32'h0000_0C89, rd, er);
        rd_chk(`SFSC_OFF_HSC, 32'h0000_0C89);
        apb(1'b1, `SFSC_OFF_HSC, 32'h0000_0000, rd, er);
        rd_chk(`SFSC_OFF_HSC, 32'h0000_0000);
        @(posedge pclk);
        hsc_set <= 32'h0000_A080;
        fire();
        rd_chk(`SFSC_OFF_HSC, 32'h0000_A080);
        @(posedge pclk);
        hsc_clr <= 32'h0000_A080;
        fire();
        rd_chk(`SFSC_OFF_HSC, 32'h0000_0000);
    endtask : t_reset_and_fields

    task automatic t_enable_escalate();
        logic [31:0] hsc;
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b0, `SFSC_OFF_HSC, 32'h0000_0000, hsc, er);
            // Read-modify-write so only this handler's enable moves
            apb(1'b1, `SFSC_OFF_HSC, hsc | (32'h0000_0001 << (16 + k)), rd, er);
            for (int en = 1; en >= 0; en--)
            begin
                @(posedge pclk);
                fault_req <= 1'b1;
                fault_kind <= k[1:0];
                fire();
                `CHK(fault_take, en ? (3'b001 << k) : 3'b000)
                `CHK(hard_fault, en ? 1'b0 : 1'b1)
                apb(1'b0, `SFSC_OFF_HSC, 32'h0000_0000, hsc, er);
                apb(1'b1, `SFSC_OFF_HSC, hsc & ~(32'h0000_0001 << (16 + k)), rd, er);
            end
        end
        apb(1'b1, `SFSC_OFF_HSC, 32'h0000_0000, rd, er);
        apb(1'b1, `SFSC_OFF_IRQ_CLR, 32'h0000_000F, rd, er);
    endtask : t_enable_escalate

    task automatic t_cause_flags();
        @(posedge pclk);
        data_fault <= 1'b1;
        data_fault_addr <= 32'h2000_0040;
        fire();
        rd_chk(`SFSC_OFF_FADDR, 32'h2000_0040);
        rd_chk(`SFSC_OFF_FCS, 32'h0000_0082);
        @(posedge pclk);
        fetch_fault <= 1'b1;
        data_fault_addr <= 32'h3000_0000;
        fire();
        @(posedge pclk);
        restore_fault <= 1'b1;
        fire();
        @(posedge pclk);
        save_fault <= 1'b1;
        lazy_fp_active <= 1'b1;
        fire();
        rd_chk(`SFSC_OFF_FADDR, 32'h2000_0040);
        rd_chk(`SFSC_OFF_FCS, 32'h0000_00BB);
        @(posedge pclk);
        bus_cause_set <= 32'hFFFF_FFFF;
        usage_cause_set <= 32'hFFFF_FFFF;
        fire();
        rd_chk(`SFSC_OFF_FCS, `SFSC_FCS_MASK);
        apb(1'b1, `SFSC_OFF_FCS, 32'h0000_0082, rd, er);
        rd_chk(`SFSC_OFF_FCS, 32'h030F_9F39);
        apb(1'b1, `SFSC_OFF_FCS, 32'hFFFF_FFFF, rd, er);
        rd_chk(`SFSC_OFF_FCS, 32'h0000_0000);
        @(posedge pclk);
        save_fault <= 1'b1;
        fire();
        rd_chk(`SFSC_OFF_FCS, 32'h0000_0010);
        rd_chk(`SFSC_OFF_FADDR, 32'h2000_0040);
        apb(1'b1, `SFSC_OFF_FCS, 32'h0000_0010, rd, er);
    endtask : t_cause_flags

    task automatic t_irq_and_map();
        apb(1'b1, `SFSC_OFF_HSC, 32'h0001_0000, rd, er);
        apb(1'b1, `SFSC_OFF_IRQ_EN, 32'h0000_0001, rd, er);
        @(posedge pclk);
        fault_req <= 1'b1;
        fault_kind <= SFSC_KIND_MEM;
        fire();
        repeat (2) @(posedge pclk);
        #1;
        `CHK(irq, 1'b1)
        rd_chk(`SFSC_OFF_IRQ_STAT, 32'h0000_0001);
        apb(1'b1, `SFSC_OFF_IRQ_CLR, 32'h0000_0001, rd, er);
        repeat (2) @(posedge pclk);
        #1;
        `CHK(irq, 1'b0)
        apb(1'b1, `SFSC_OFF_IRQ_EN, 32'h0000_0000, rd, er);
        @(posedge pclk);
        fault_req <= 1'b1;
        fire();
        repeat (2) @(posedge pclk);
        #1;
        `CHK(irq, 1'b0)
        rd_chk(`SFSC_OFF_IRQ_CLR, 32'h0000_0000);
        apb(1'b1, `SFSC_OFF_IRQ_STAT, 32'h0000_0000, rd, er);
        rd_chk(`SFSC_OFF_IRQ_STAT, 32'h0000_0001);
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF, rd, er);
        `CHK(er, 1'b1)
        rd_chk(12'h0FC, 32'h0000_0000);
        `CHK(er, 1'b1)
        // Both memory faults were taken, so their pending bit stays up
        rd_chk(`SFSC_OFF_HSC, 32'h0001_2000);
        // An undefined fault kind has no handler and must escalate
        @(posedge pclk);
        fault_req <= 1'b1;
        fault_kind <= 2'b11;
        fire();
        `CHK(hard_fault, 1'b1)
        rd_chk(`SFSC_OFF_HARD, 32'h0000_0004);
        apb(1'b1, `SFSC_OFF_FADDR, 32'h1234_5678, rd, er);
        rd_chk(`SFSC_OFF_FADDR, 32'h1234_5678);
        // Reset in mid-run must bring the handler state and fault address back to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`SFSC_OFF_HSC, `SFSC_HSC_RESET);
        rd_chk(`SFSC_OFF_FADDR, 32'h0000_0000);
    endtask : t_irq_and_map

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_and_fields();
        t_enable_escalate();
        t_cause_flags();
        t_irq_and_map();
        tally_and_finish();
    end
endmodule : tb_top
